// >>> hw/cdr_regs.sv
// CPU dedicated register set with condition flags and bank pointer
//
// Operation
// - Instruction pointer is 16 bits, steps on fetch, resets to FFFD.
// - Both accumulators are 16 bits; byte operations use only low bytes.
// - Index, extra pointer and stack pointer are 16 bits, no reset value.
// - Status word: upper byte is bank select, lower byte the flags.
// - Interrupt enable flag permits interrupts at 1; cleared on reset.
// - Mask level admits only higher requests; levels 0 and 1 admit none.
// - Half carry reflects carry or borrow between bits 3 and 4.
// - Negative flag copies the result's most significant bit.
// - Zero flag is set only for a zero result.
// - Overflow flag shows two's-complement overflow of the result.
// - Carry flag is carry or borrow out; shifts load the bit shifted out.
// - Eight-bit general registers sit in memory, eight per bank.
// - Usable banks depend on RAM: 16 small, up to 32 larger.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "cdr_map.svh"

module cdr_regs #(
  parameter int             BANK_BITS = `CDR_BANK_BITS,
  parameter logic [15:0]    BANK_BASE = `CDR_BANK_BASE
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  input  wire logic [`CDR_ADDR_W-1:0]    i_addr,
  input  wire logic [15:0]               i_wr_data,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [15:0]               o_rd_data,
  input  wire logic                      i_ip_step,
  input  wire logic                      i_alu_go,
  input  wire cdr_pkg::cdr_alu_op_t      i_alu_op,
  input  wire logic                      i_alu_word,
  input  wire logic                      i_irq_req,
  input  wire logic [1:0]                i_irq_level,
  output logic                           o_irq_take,
  output logic      [15:0]               o_ip,
  output logic      [15:0]               o_psw,
  output logic      [15:0]               o_bank_addr
);
  import cdr_pkg::*;

  // ****************************************************************
  // Level decoding
  // ****************************************************************
  // Codes 00 and 01 both mean the top level; smaller is more urgent
  function automatic logic [1:0] lvl_of(input logic [1:0] code);
    logic [1:0] l;
    l = 2'h1;
    if (code == 2'h2) begin
      l = 2'h2;
    end else if (code == 2'h3) begin
      l = 2'h3;
    end
    return l;
  endfunction : lvl_of

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] ip_q;
  logic [15:0] acc_q;
  logic [15:0] tacc_q;
  logic [15:0] index_q;
  logic [15:0] extra_q;
  logic [15:0] stack_q;
  logic [15:0] psw_q;
  logic [15:0] psw_d;
  logic [15:0] res_d;
  logic        wr_ip;
  logic        wr_acc;
  logic        wr_psw;

  assign wr_ip  = i_wr && (i_addr == `CDR_IDX_IP);
  assign wr_acc = i_wr && (i_addr == `CDR_IDX_ACC);
  assign wr_psw = i_wr && (i_addr == `CDR_IDX_PSW);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ip_q <= `CDR_IP_RST;
    end else if (wr_ip) begin
      ip_q <= i_wr_data;
    end else if (i_ip_step) begin
      ip_q <= ip_q + 16'h0001;
    end
  end

  // Bus write wins over an arithmetic result in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= `CDR_WORD_RST;
    end else if (wr_acc) begin
      acc_q <= i_wr_data;
    end else if (i_alu_go) begin
      acc_q <= res_d;
    end
  end

  // Contents after reset carry no meaning; zero only keeps sims clean
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tacc_q  <= `CDR_WORD_RST;
      index_q <= `CDR_WORD_RST;
      extra_q <= `CDR_WORD_RST;
      stack_q <= `CDR_WORD_RST;
    end else if (i_wr) begin
      if (i_addr == `CDR_IDX_TACC) begin
        tacc_q <= i_wr_data;
      end else if (i_addr == `CDR_IDX_INDEX) begin
        index_q <= i_wr_data;
      end else if (i_addr == `CDR_IDX_EXTRA) begin
        extra_q <= i_wr_data;
      end else if (i_addr == `CDR_IDX_STACK) begin
        stack_q <= i_wr_data;
      end
    end
  end

  // ****************************************************************
  // Arithmetic and flag computation
  // ****************************************************************
  logic [15:0] opa;
  logic [15:0] opb;
  logic [16:0] sum;
  logic [4:0]  nib;
  logic        a_m;
  logic        b_m;
  logic        r_m;

  always_comb begin
    opa   = i_alu_word ? acc_q  : {8'h00, acc_q[7:0]};
    opb   = i_alu_word ? tacc_q : {8'h00, tacc_q[7:0]};
    sum   = 17'h00000;
    nib   = 5'h00;
    res_d = acc_q;
    psw_d = psw_q;
    a_m   = i_alu_word ? opa[15] : opa[7];
    b_m   = i_alu_word ? opb[15] : opb[7];
    case (i_alu_op)
      cdr_op_add: begin
        sum = {1'b0, opa} + {1'b0, opb};
        nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
      end
      cdr_op_sub: begin
        sum = {1'b0, opa} - {1'b0, opb};
        nib = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
      end
      cdr_op_shl: begin
        sum = {1'b0, opa[14:0], 1'b0};
      end
      default: begin
        sum = {2'h0, opa[15:1]};
      end
    endcase
    // Byte work leaves the accumulator's upper byte alone
    res_d = i_alu_word ? sum[15:0] : {acc_q[15:8], sum[7:0]};
    r_m   = i_alu_word ? sum[15] : sum[7];
    psw_d[`CDR_BIT_N] = r_m;
    psw_d[`CDR_BIT_Z] = i_alu_word ? (sum[15:0] == 16'h0000)
                                   : (sum[7:0] == 8'h00);
    case (i_alu_op)
      cdr_op_add: begin
        psw_d[`CDR_BIT_H] = nib[4];
        psw_d[`CDR_BIT_V] = (a_m == b_m) && (r_m != a_m);
        psw_d[`CDR_BIT_C] = i_alu_word ? sum[16] : sum[8];
      end
      cdr_op_sub: begin
        psw_d[`CDR_BIT_H] = nib[4];
        psw_d[`CDR_BIT_V] = (a_m != b_m) && (r_m != a_m);
        psw_d[`CDR_BIT_C] = i_alu_word ? sum[16] : sum[8];
      end
      cdr_op_shl: begin
        psw_d[`CDR_BIT_C] = a_m;
      end
      default: begin
        psw_d[`CDR_BIT_C] = opa[0];
      end
    endcase
  end

  // ****************************************************************
  // Status word
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      psw_q <= `CDR_PSW_RST;
    end else if (wr_psw) begin
      psw_q <= i_wr_data;
    end else if (i_alu_go) begin
      psw_q <= psw_d;
    end
  end

  // ****************************************************************
  // Interrupt admission and bank address
  // ****************************************************************
  logic [1:0] il;
  assign il = psw_q[`CDR_BIT_IL_HI:`CDR_BIT_IL_LO];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_take <= 1'b0;
    end else begin
      o_irq_take <= i_irq_req && psw_q[`CDR_BIT_I]
                    && (lvl_of(i_irq_level) < lvl_of(il));
    end
  end

  // Upper pointer bits beyond the fitted RAM are ignored, so the bank wraps
  logic [15:0] bank_off;
  assign bank_off = 16'({psw_q[8 +: BANK_BITS], 3'b000});

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bank_addr <= BANK_BASE;
    end else begin
      o_bank_addr <= BANK_BASE + bank_off;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ip  <= `CDR_IP_RST;
      o_psw <= `CDR_PSW_RST;
    end else begin
      o_ip  <= ip_q;
      o_psw <= psw_q;
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd) begin
      if (i_addr == `CDR_IDX_IP) begin
        o_rd_data <= ip_q;
      end else if (i_addr == `CDR_IDX_ACC) begin
        o_rd_data <= acc_q;
      end else if (i_addr == `CDR_IDX_TACC) begin
        o_rd_data <= tacc_q;
      end else if (i_addr == `CDR_IDX_INDEX) begin
        o_rd_data <= index_q;
      end else if (i_addr == `CDR_IDX_EXTRA) begin
        o_rd_data <= extra_q;
      end else if (i_addr == `CDR_IDX_STACK) begin
        o_rd_data <= stack_q;
      end else if (i_addr == `CDR_IDX_PSW) begin
        o_rd_data <= psw_q;
      end else begin
        o_rd_data <= 16'h0000;
      end
    end else begin
      o_rd_data <= 16'h0000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  logic alu_b;
  assign alu_b = i_alu_go && !i_wr && !i_alu_word;

  property p_ip_step;
    i_ip_step && !i_wr |=> ip_q == $past(ip_q) + 16'h0001;
  endproperty
  a_ip_step: assert property (p_ip_step)
    else $error("ip did not step");

  property p_rd_ip;
    i_rd && i_addr == `CDR_IDX_IP |=> o_rd_data == $past(ip_q);
  endproperty
  a_rd_ip: assert property (p_rd_ip)
    else $error("ip readback wrong");

  property p_keep_high;
    alu_b |=> acc_q[15:8] == $past(acc_q[15:8]);
  endproperty
  a_keep_high: assert property (p_keep_high)
    else $error("byte op touched upper byte");

  property p_add_c;
    alu_b && i_alu_op == cdr_op_add |=>
      psw_q[`CDR_BIT_C] == ((9'($past(acc_q[7:0])) + 9'($past(tacc_q[7:0]))) > 9'h0FF);
  endproperty
  a_add_c: assert property (p_add_c)
    else $error("carry wrong");

  property p_add_h;
    alu_b && i_alu_op == cdr_op_add |=>
      psw_q[`CDR_BIT_H] == ((5'($past(acc_q[3:0])) + 5'($past(tacc_q[3:0]))) > 5'h0F);
  endproperty
  a_add_h: assert property (p_add_h)
    else $error("half carry wrong");

  property p_nz;
    alu_b |=> psw_q[`CDR_BIT_Z] == (acc_q[7:0] == 8'h00) && psw_q[`CDR_BIT_N] == acc_q[7];
  endproperty
  a_nz: assert property (p_nz)
    else $error("zero or negative flag wrong");

  property p_irq_off;
    !psw_q[`CDR_BIT_I] || !i_irq_req || i_irq_level == 2'h3 |=> !o_irq_take;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt admitted while blocked");

  property p_irq_top;
    i_irq_req && psw_q[`CDR_BIT_I] && i_irq_level == 2'h0 && il == 2'h2 |=> o_irq_take;
  endproperty
  a_irq_top: assert property (p_irq_top)
    else $error("top level request refused");

  property p_bank;
    ##1 o_bank_addr == BANK_BASE + 16'({$past(psw_q[8 +: BANK_BITS]), 3'b000});
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank address wrong");

  property p_add_v;
    alu_b && i_alu_op == cdr_op_add |=>
      psw_q[`CDR_BIT_V] == (($past(acc_q[7]) == $past(tacc_q[7]))
                            && (acc_q[7] != $past(acc_q[7])));
  endproperty
  a_add_v: assert property (p_add_v)
    else $error("overflow flag wrong");

  property p_sub_c;
    alu_b && i_alu_op == cdr_op_sub |=>
      psw_q[`CDR_BIT_C] == ($past(acc_q[7:0]) < $past(tacc_q[7:0]));
  endproperty
  a_sub_c: assert property (p_sub_c)
    else $error("borrow wrong");

  property p_shl_c;
    alu_b && i_alu_op == cdr_op_shl |=> psw_q[`CDR_BIT_C] == $past(acc_q[7]);
  endproperty
  a_shl_c: assert property (p_shl_c)
    else $error("shift carry wrong");

  property p_psw_wr;
    i_wr && i_addr == `CDR_IDX_PSW |=> psw_q == $past(i_wr_data);
  endproperty
  a_psw_wr: assert property (p_psw_wr)
    else $error("status word write lost");

endmodule : cdr_regs

// >>> hw/cdr_map.svh
// Offsets, field positions, reset values and constants of the register set
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

`define CDR_ADDR_W      3
`define CDR_IDX_IP      3'h0
`define CDR_IDX_ACC     3'h1
`define CDR_IDX_TACC    3'h2
`define CDR_IDX_INDEX   3'h3
`define CDR_IDX_EXTRA   3'h4
`define CDR_IDX_STACK   3'h5
`define CDR_IDX_PSW     3'h6

`define CDR_IP_RST      16'hFFFD
`define CDR_PSW_RST     16'h0030
`define CDR_WORD_RST    16'h0000

`define CDR_BIT_H       7
`define CDR_BIT_I       6
`define CDR_BIT_IL_HI   5
`define CDR_BIT_IL_LO   4
`define CDR_BIT_N       3
`define CDR_BIT_Z       2
`define CDR_BIT_V       1
`define CDR_BIT_C       0

`define CDR_BANK_BASE   16'h0100
`define CDR_BANK_SHIFT  3
`define CDR_BANK_BITS   5

`endif

// >>> hw/cdr_pkg.sv
// Types shared by the dedicated register set
package cdr_pkg;

  typedef enum logic [1:0] {
    cdr_op_add,
    cdr_op_sub,
    cdr_op_shl,
    cdr_op_shr
  } cdr_alu_op_t;

endpackage : cdr_pkg

// >>> testbench/test_cpu_dedicated_register_set.sv
// Self-checking bench for the dedicated register set
`timescale 1ns/1ps
`include "cdr_map.svh"

module test_cpu_dedicated_register_set;
  import cdr_pkg::*;
  localparam int          BB   = 4;
  localparam logic [15:0] BASE = 16'h0100;
  logic        i_core_clk, i_rst, i_wr, i_rd, i_ip_step, i_alu_go, i_alu_word;
  logic        i_irq_req, o_irq_take;
  logic [2:0]  i_addr;
  logic [1:0]  i_irq_level;
  logic [15:0] i_wr_data, o_rd_data, o_ip, o_psw, o_bank_addr;
  cdr_alu_op_t i_alu_op;
  logic [15:0] m [8];
  int          fails, checks;

  cdr_regs #(.BANK_BITS(BB), .BANK_BASE(BASE)) i_cdr_regs (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_ip_step(i_ip_step),
    .i_alu_go(i_alu_go), .i_alu_op(i_alu_op), .i_alu_word(i_alu_word),
    .i_irq_req(i_irq_req), .i_irq_level(i_irq_level), .o_irq_take(o_irq_take),
    .o_ip(o_ip), .o_psw(o_psw), .o_bank_addr(o_bank_addr));

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // ************************************************************
  // Bus tasks and comparison
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1; i_addr <= a; i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    if (a != 3'h7) m[a] = d;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk(o_rd_data, m[a]);
  endtask : rd

  task automatic alu(input cdr_alu_op_t op, input logic w);
    logic [16:0] r;
    logic [15:0] a, b;
    int          s;
    a = m[1]; b = m[2]; s = w ? 15 : 7;
    if (!w) begin
      a[15:8] = 8'h00; b[15:8] = 8'h00;
    end
    @(posedge i_core_clk);
    i_alu_go <= 1'b1; i_alu_op <= op; i_alu_word <= w;
    @(posedge i_core_clk);
    i_alu_go <= 1'b0;
    case (op)
      cdr_op_add: r = a + b;
      cdr_op_sub: r = a - b;
      cdr_op_shl: r = {a, 1'b0};
      default:    r = {1'b0, a >> 1};
    endcase
    if (op == cdr_op_add || op == cdr_op_sub) begin
      m[6][7] = a[4] ^ b[4] ^ r[4];
      m[6][1] = (op == cdr_op_add ? a[s] == b[s] : a[s] != b[s]) && r[s] != a[s];
      m[6][0] = r[s + 1];
    end else begin
      m[6][0] = (op == cdr_op_shl) ? a[s] : a[0];
    end
    m[6][3] = r[s];
    m[6][2] = w ? r[15:0] == 16'h0000 : r[7:0] == 8'h00;
    m[1] = w ? r[15:0] : {m[1][15:8], r[7:0]};
    rd(3'h1);
    rd(3'h6);
  endtask : alu

  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [15:0] d;
    logic [15:0] va [6];
    int          lt, lr;
    {i_wr, i_rd, i_ip_step, i_alu_go, i_alu_word, i_irq_req} = 6'h00;
    i_addr = 3'h0; i_wr_data = 16'h0000; i_irq_level = 2'h0; i_alu_op = cdr_op_add;
    fails = 0; checks = 0; i_rst = 1'b1;
    m = '{default: 16'h0000};
    m[0] = `CDR_IP_RST; m[6] = `CDR_PSW_RST;
    va = '{16'h000F, 16'h0001, 16'h007F, 16'h00FF, 16'h7FFF, 16'h8000};
    void'($urandom(47));
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk(o_ip, 16'hFFFD);
    rd(3'h0);
    chk({15'h0000, o_psw[`CDR_BIT_I]}, 16'h0000);
    rd(3'h6);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      wr(i[2:0], 16'($urandom));
      rd(i[2:0]);
    end
    @(posedge i_core_clk);
    i_ip_step <= 1'b1;
    @(posedge i_core_clk);
    i_ip_step <= 1'b0;
    m[0] = m[0] + 16'h0001;
    rd(3'h0);
    chk(o_ip, m[0]);
    $display("test registers done");

    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom);
      wr(3'h6, d);
      repeat (2) @(posedge i_core_clk);
      #1 chk(o_psw, d);
      chk(o_bank_addr, BASE + 16'((d[15:8] & ((1 << BB) - 1)) * 8));
    end
    $display("test bank done");

    for (int i = 0; i < 48; i++) begin
      wr(3'h1, i < 6 ? va[i] : 16'($urandom));
      wr(3'h2, i < 6 ? va[5 - i] : 16'($urandom));
      alu(cdr_alu_op_t'(i % 4), 1'(i / 4));
    end
    $display("test alu done");

    for (int i = 0; i < 64; i++) begin
      wr(3'h6, {8'h00, 1'b0, 1'(i / 32), 2'(i / 8), 4'h0});
      @(posedge i_core_clk);
      i_irq_req <= 1'(i / 4); i_irq_level <= 2'(i);
      repeat (2) @(posedge i_core_clk);
      lt = (i / 8) % 4 == 3 ? 3 : (i / 8) % 4 == 2 ? 2 : 1;
      lr = i % 4 == 3 ? 3 : i % 4 == 2 ? 2 : 1;
      #1 chk({15'h0000, o_irq_take}, 16'(i / 4 % 2 == 1 && i >= 32 && lr < lt));
    end
    i_irq_req <= 1'b0;
    $display("test interrupt done");
    print_verdict();
  end
endmodule : test_cpu_dedicated_register_set
